// ===== rtl/asq_core.sv
`timescale 1ns/1ps
// Behaviour
// R1 - conversion done sets its location flag
// R2 - only enabled flags reach the interrupt
// R3 - pending status is flags AND enables
// R4 - in-window flag between thresholds
// R5 - below-window flag under low threshold
// R6 - above-window flag over high threshold
// R7 - overflow when unread location overwritten
// R8 - timing overflow on start while busy
// R9 - reference ready raises its flag
// R10 - module stays on while converting
// R11 - burst mode: reference on only busy
// R12 - timer off: trigger width sets sampling
// R13 - two windows, per-location enable, select
// R14 - enable arms; trigger starts conversion
// R15 - manual iteration needs new trigger
// R16 - timer on: automatic iteration restarts sampling
// R17 - conversion lasts 10/12/14/16 ticks
// R18 - results unsigned or two's complement
// R19 - protected settings locked while busy
// R20 - one 16-bit result per location
// R21 - sequence runs first to last location
// R22 - clear only the named flags
// R23 - busy while sampling or converting
// R24 - flags stay set until cleared
module asq_core
  import asq_pkg::*;
(
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_SYS_RST,
  // register port
  input  wire logic [6:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // converter core
  input  wire logic        I_TRIG,
  input  wire logic [13:0] I_CONV_DATA,
  input  wire logic        I_REF_READY,
  output logic             O_SAMPLE,
  output logic             O_CONVERT,
  output logic             O_MOD_ON,
  output logic             O_REF_ON,
  output logic             O_BUSY,
  output logic             O_IRQ
);

  function automatic logic [4:0] res_bits(logic [1:0] r);
    res_bits = RES_BASE + {2'h0, r, 1'b0};
  endfunction

  function automatic logic [4:0] conv_len(logic [1:0] r);
    conv_len = CONV_BASE + {2'h0, r, 1'b0};
  endfunction

  // raw code is right-justified at the current resolution
  function automatic logic [15:0] fmt_res(logic [13:0] raw,
                                          logic [1:0]  r,
                                          logic        sgn);
    logic [15:0] m;
    logic [15:0] half;
    m    = {2'h0, raw} & ((16'h1 << res_bits(r)) - 16'h1);
    half = 16'h1 << (res_bits(r) - 5'h1);
    fmt_res = sgn ? m - half : m;
  endfunction

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  asq_ctrl_t       ctrl;
  asq_seq_t        seq;
  asq_win_t        win0;
  asq_win_t        win1;
  asq_state_t      state;
  logic [NLOC-1:0] ie;
  logic [NX-1:0]   iex;
  logic [NLOC-1:0] ifg;
  logic [NX-1:0]   ifgx;
  logic [NLOC-1:0] wen;
  logic [NLOC-1:0] wsel;
  logic [NLOC-1:0] unread;
  logic [15:0]     mem [NLOC];
  logic [4:0]      loc;
  logic [4:0]      cnt;
  logic [7:0]      div_cnt;
  logic            samp_prev;
  logic            rdy_prev;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        busy     = state != S_IDLE;
  wire        wr_ctrl  = I_WR && I_ADDR == A_CTRL;
  wire        wr_seq   = I_WR && I_ADDR == A_SEQ;
  wire        lock_ok  = I_WR && !busy;
  wire        tick     = div_cnt == DIV_TICKS - 8'h01;
  wire        samp_in  = ctrl.sw_trig | I_TRIG;
  wire        samp_ris = samp_in && !samp_prev;
  // R14 arm only
  wire        armed    = ctrl.conv_en && ctrl.mod_on;
  wire        start    = !busy && armed && samp_ris;
  // R8 start while busy
  wire        tov_evt  = busy && armed && samp_ris;
  wire        samp_end = ctrl.timer_en
                         ? tick && cnt == SAMPLE_TICKS - 5'h1
                         : !samp_in;
  // R17 conversion length
  wire        fin      = state == S_CONVERT && tick
                         && cnt == conv_len(ctrl.res) - 5'h1;
  wire        last     = !ctrl.seq_mode || loc == seq.last;
  // R18 result data format
  wire [15:0] res_val  = fmt_res(I_CONV_DATA, ctrl.res,
                                 ctrl.fmt_signed);
  wire        rd_res   = I_RD && I_ADDR[6:5] == RES_PAGE;

  // ----------------------------------------------------------------
  // window comparators
  // ----------------------------------------------------------------
  // R13 per-location window
  wire        chk   = fin && wen[loc];
  wire [15:0] lo_th = wsel[loc] ? win1.low : win0.low;
  wire [15:0] hi_th = wsel[loc] ? win1.high : win0.high;
  wire        below = ctrl.fmt_signed
                      ? $signed(res_val) < $signed(lo_th)
                      : res_val < lo_th;
  wire        above = ctrl.fmt_signed
                      ? $signed(res_val) > $signed(hi_th)
                      : res_val > hi_th;

  // ----------------------------------------------------------------
  // flag update
  // ----------------------------------------------------------------
  logic [NLOC-1:0] set_m;
  logic [NX-1:0]   setx_m;
  logic [NLOC-1:0] clr_m;
  logic [NX-1:0]   clrx_m;
  // R1 completion flag
  assign set_m  = fin ? NLOC'(1) << loc : '0;
  // R4 R5 R6 R7 R8 R9 event sources
  assign setx_m[X_IN]  = chk && !below && !above;
  assign setx_m[X_LO]  = chk && below;
  assign setx_m[X_HI]  = chk && above;
  assign setx_m[X_OV]  = fin && unread[loc];
  assign setx_m[X_TOV] = tov_evt;
  assign setx_m[X_RDY] = I_REF_READY && !rdy_prev;
  // R22 named bits only
  assign clr_m  = (I_WR && I_ADDR == A_CLR) ? I_WDATA : '0;
  assign clrx_m = (I_WR && I_ADDR == A_CLRX) ? I_WDATA[NX-1:0] : '0;

  // R24 sticky, set beats clear
  wire [NLOC-1:0] next_ifg  = (ifg & ~clr_m) | set_m;
  wire [NX-1:0]   next_ifgx = (ifgx & ~clrx_m) | setx_m;
  // R3 pending view
  wire [NLOC-1:0] pend  = ifg & ie;
  wire [NX-1:0]   pendx = ifgx & iex;

  // ----------------------------------------------------------------
  // protected control writes
  // ----------------------------------------------------------------
  asq_ctrl_t wctl;
  asq_ctrl_t next_ctrl;
  assign wctl = asq_ctrl_t'(I_WDATA[$bits(asq_ctrl_t)-1:0]);
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl && !busy) begin
      next_ctrl = wctl;
    end else if (wr_ctrl) begin
      // R19 locked while busy
      // R10 module stays on
      next_ctrl.sw_trig = wctl.sw_trig;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  asq_state_t next_state;
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (start) begin
          next_state = S_SAMPLE;
        end
      end
      S_SAMPLE: begin
        // R12 trigger width when timer off
        if (samp_end) begin
          next_state = S_CONVERT;
        end
      end
      S_CONVERT: begin
        // R15 R16 iteration
        if (fin && !last && ctrl.timer_en && ctrl.auto_iter) begin
          next_state = S_SAMPLE;
        end else if (fin) begin
          next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      state   <= S_IDLE;
      cnt     <= 5'h0;
      div_cnt <= 8'h00;
    end else begin
      state   <= next_state;
      // R17 divider restarts at every phase change, so a phase
      // entered between ticks still lasts whole converter ticks
      div_cnt <= (tick || next_state != state) ? 8'h00
                                               : div_cnt + 8'h01;
      if (next_state != state) begin
        cnt <= 5'h0;
      end else if (busy && tick) begin
        cnt <= cnt + 5'h1;
      end
    end
  end

  // R21 sequence location
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      loc <= 5'h0;
    end else if (wr_seq && !busy) begin
      loc <= I_WDATA[4:0];
    end else if (fin) begin
      loc <= last ? seq.first : loc + 5'h1;
    end
  end

  // R20 result store
  always_ff @(posedge I_CLK) begin
    if (fin) begin
      mem[loc] <= res_val;
    end
  end

  // unread set wins over a same-cycle read
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      unread <= '0;
    end else begin
      unread <= (unread & ~(rd_res ? NLOC'(1) << I_ADDR[4:0] : '0))
                | set_m;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctrl <= CTRL_RST;
      seq  <= '0;
      ie   <= '0;
      iex  <= '0;
      wen  <= '0;
      wsel <= '0;
      win0 <= '0;
      win1 <= '0;
    end else begin
      ctrl <= next_ctrl;
      if (lock_ok && I_ADDR == A_SEQ) begin
        seq <= asq_seq_t'(I_WDATA[9:0]);
      end
      if (I_WR && I_ADDR == A_IE) begin
        ie <= I_WDATA;
      end
      if (I_WR && I_ADDR == A_IEX) begin
        iex <= I_WDATA[NX-1:0];
      end
      // R19 window setup locked
      if (lock_ok && I_ADDR == A_WEN) begin
        wen <= I_WDATA;
      end
      if (lock_ok && I_ADDR == A_WSEL) begin
        wsel <= I_WDATA;
      end
      if (lock_ok && I_ADDR == A_WIN0) begin
        win0 <= I_WDATA;
      end
      if (lock_ok && I_ADDR == A_WIN1) begin
        win1 <= I_WDATA;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ifg       <= '0;
      ifgx      <= '0;
      samp_prev <= 1'b0;
      rdy_prev  <= 1'b0;
      O_IRQ     <= 1'b0;
    end else begin
      ifg       <= next_ifg;
      ifgx      <= next_ifgx;
      samp_prev <= samp_in;
      rdy_prev  <= I_REF_READY;
      // R2 enabled sources only
      O_IRQ     <= |pend || |pendx;
    end
  end

  // read data stands one cycle after the strobe
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (rd_res) begin
      rd_mux = {16'h0, mem[I_ADDR[4:0]]};
    end else begin
      case (I_ADDR)
        A_CTRL:  rd_mux = 32'(ctrl);
        A_SEQ:   rd_mux = 32'(seq);
        A_IE:    rd_mux = ie;
        A_IEX:   rd_mux = 32'(iex);
        A_IFG:   rd_mux = ifg;
        A_IFGX:  rd_mux = 32'(ifgx);
        A_PEND:  rd_mux = pend;
        A_PNDX:  rd_mux = 32'(pendx);
        A_WEN:   rd_mux = wen;
        A_WSEL:  rd_mux = wsel;
        A_WIN0:  rd_mux = win0;
        A_WIN1:  rd_mux = win1;
        A_STAT:  rd_mux = {26'h0, loc, busy};
        default: rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_RDATA <= 32'h0;
    end else begin
      O_RDATA <= I_RD ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign O_SAMPLE  = state == S_SAMPLE;
  assign O_CONVERT = state == S_CONVERT;
  // R23 busy status
  assign O_BUSY    = busy;
  // R10 module held on
  assign O_MOD_ON  = ctrl.mod_on;
  // R11 reference burst
  assign O_REF_ON  = !ctrl.ref_burst || busy;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  a_done_flag: assert property (fin |=> ifg[$past(loc)]) // R1
    else $error("done flag not set");
  a_irq_gate: assert property (!(|pend) && !(|pendx) |=> !O_IRQ) // R2
    else $error("irq without enabled flag");
  a_pend_read: assert property ( // R3
    I_RD && I_ADDR == A_PEND |=> O_RDATA == $past(pend))
    else $error("pending read mismatch");
  a_ov_flag: assert property (fin && unread[loc] |=> ifgx[X_OV]) // R7
    else $error("overflow flag missing");
  a_tov_flag: assert property (tov_evt |=> ifgx[X_TOV]) // R8
    else $error("timing overflow flag missing");
  a_mod_hold: assert property (busy |-> O_MOD_ON) // R10
    else $error("module off while busy");
  a_ref_burst: assert property ( // R11
    ctrl.ref_burst && !busy |-> !O_REF_ON)
    else $error("reference on while idle in burst");
  a_arm_only: assert property ( // R14
    state == S_IDLE && !samp_ris |=> state == S_IDLE)
    else $error("start without trigger");
  a_cfg_lock: assert property ( // R19
    busy && wr_ctrl |=> ctrl.conv_en == $past(ctrl.conv_en))
    else $error("enable changed while busy");
  a_flag_stick: assert property ( // R24
    ifg[0] && !clr_m[0] |=> ifg[0])
    else $error("flag dropped without clear");

  c_seq_wrap: cover property (fin && ctrl.seq_mode && last);
  c_overflow: cover property (setx_m[X_OV]);
  c_auto_iter: cover property (fin && ctrl.auto_iter && !last);
  c_in_window: cover property (setx_m[X_IN]);
endmodule

// ===== rtl/asq_pkg.sv
package asq_pkg;
  localparam int NLOC = 32;
  localparam int NX   = 6;
  // register indices on the plain port
  localparam logic [6:0] A_CTRL = 7'h00;
  localparam logic [6:0] A_SEQ  = 7'h01;
  localparam logic [6:0] A_IE   = 7'h02;
  localparam logic [6:0] A_IEX  = 7'h03;
  localparam logic [6:0] A_IFG  = 7'h04;
  localparam logic [6:0] A_IFGX = 7'h05;
  localparam logic [6:0] A_CLR  = 7'h06;
  localparam logic [6:0] A_CLRX = 7'h07;
  localparam logic [6:0] A_PEND = 7'h08;
  localparam logic [6:0] A_PNDX = 7'h09;
  localparam logic [6:0] A_WEN  = 7'h0a;
  localparam logic [6:0] A_WSEL = 7'h0b;
  localparam logic [6:0] A_WIN0 = 7'h0c;
  localparam logic [6:0] A_WIN1 = 7'h0d;
  localparam logic [6:0] A_STAT = 7'h0e;
  localparam logic [1:0] RES_PAGE = 2'h1;
  // extra flag positions
  localparam int X_IN  = 0;
  localparam int X_LO  = 1;
  localparam int X_HI  = 2;
  localparam int X_OV  = 3;
  localparam int X_TOV = 4;
  localparam int X_RDY = 5;
  // resolution codes
  localparam logic [1:0] RES_EIGHT    = 2'h0;
  localparam logic [1:0] RES_FOURTEEN = 2'h3;
  // divider in clocks per tick, timing in converter clock ticks, base resolution in bits
  localparam logic [7:0] DIV_TICKS    = 8'h04;
  localparam logic [4:0] SAMPLE_TICKS = 5'h04;
  localparam logic [4:0] CONV_BASE    = 5'h0a;
  localparam logic [4:0] RES_BASE     = 5'h08;

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONVERT} asq_state_t;

  typedef struct packed {
    logic [1:0] res;
    logic       fmt_signed;
    logic       seq_mode;
    logic       ref_burst;
    logic       auto_iter;
    logic       timer_en;
    logic       sw_trig;
    logic       conv_en;
    logic       mod_on;
  } asq_ctrl_t;

  typedef struct packed {
    logic [4:0] last;
    logic [4:0] first;
  } asq_seq_t;

  typedef struct packed {
    logic [15:0] high;
    logic [15:0] low;
  } asq_win_t;

  localparam asq_ctrl_t CTRL_RST = '{res: RES_FOURTEEN, default: 1'b0};
endpackage

// ===== verif/adc_sequencer_interrupt_control_test.sv
`timescale 1ns/1ps
module adc_sequencer_interrupt_control_test;
  import asq_pkg::*;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        I_CLK       = 1'b0;
  logic        I_SYS_RST   = 1'b1;
  logic [6:0]  I_ADDR      = 7'h00;
  logic [31:0] I_WDATA     = 32'h0;
  logic        I_WR        = 1'b0;
  logic        I_RD        = 1'b0;
  logic        I_TRIG      = 1'b0;
  logic [13:0] I_CONV_DATA = 14'h0;
  logic        I_REF_READY = 1'b0;
  logic [31:0] O_RDATA;
  logic        O_SAMPLE;
  logic        O_CONVERT;
  logic        O_MOD_ON;
  logic        O_REF_ON;
  logic        O_BUSY;
  logic        O_IRQ;
  int          failures    = 0;
  int          num_checks  = 0;
  int          ncv;
  int          cyc         = 0;
  logic [31:0] d;

  always #4 I_CLK = ~I_CLK;

  asq_core dut (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .I_TRIG(I_TRIG), .I_CONV_DATA(I_CONV_DATA),
    .I_REF_READY(I_REF_READY), .O_SAMPLE(O_SAMPLE),
    .O_CONVERT(O_CONVERT), .O_MOD_ON(O_MOD_ON), .O_REF_ON(O_REF_ON),
    .O_BUSY(O_BUSY), .O_IRQ(O_IRQ)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    @(posedge I_CLK);
    I_WR    <= 1'b1;
    I_ADDR  <= a;
    I_WDATA <= v;
    @(posedge I_CLK);
    I_WR    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [6:0] a);
    @(posedge I_CLK);
    I_RD   <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CLK);
    I_RD   <= 1'b0;
    #1 d = O_RDATA;
  endtask

  task automatic rdc(input string n, input logic [6:0] a,
                     input logic [31:0] e);
    rd(a);
    chk(n, e, d);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask

  // counts convert cycles until the run ends, bounded
  task automatic wait_idle();
    int i;
    ncv = 0;
    for (i = 0; i < 800; i++) begin
      @(posedge I_CLK);
      #1;
      if (O_CONVERT === 1'b1) ncv++;
      if (i > 4 && O_BUSY !== 1'b1) break;
    end
    if (i == 800) begin
      failures++;
      $display("unexpected busy expected 0 seen 1");
    end
  endtask

  task automatic go(input logic [31:0] c);
    wr(A_CTRL, c);
    wr(A_CTRL, c | 32'h4);
    wait_idle();
  endtask

  task automatic clr_all();
    wr(A_CLR, 32'hffffffff);
    wr(A_CLRX, 32'h3f);
  endtask

  // ---------------------------------------------------------------
  // hang guard
  // ---------------------------------------------------------------
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    rdc("ctrl_reset", A_CTRL, 32'h300);
    rdc("unmapped", 7'h7f, 32'h0);
    chk("ref_on_reset", 32'h1, {31'h0, O_REF_ON});
    chk("mod_on_reset", 32'h0, {31'h0, O_MOD_ON});
    wr(A_WIN0, 32'h0080_0010);
    wr(A_WIN1, 32'h0300_0200);
    wr(A_WEN, 32'h1);
    wr(A_IE, 32'h1);
    wr(A_SEQ, 32'h0);
    wr(A_CTRL, 32'h3);
    tick(20);
    chk("armed_idle", 32'h0, {31'h0, O_BUSY});
    // every resolution, in-window result at location 0
    I_CONV_DATA <= 14'h40;
    for (int r = 0; r < 4; r++) begin
      go(32'h0b | (r << 8));
      chk("conv_len", int'(DIV_TICKS) * (int'(CONV_BASE) + 2 * r), ncv);
      rdc("result", 7'h20, 32'h40);
      rdc("ifg", A_IFG, 32'h1);
      rdc("ifgx_in", A_IFGX, 32'h1);
      rdc("pend", A_PEND, 32'h1);
      chk("irq_on", 32'h1, {31'h0, O_IRQ});
      clr_all();
      tick(2);
      chk("irq_off", 32'h0, {31'h0, O_IRQ});
    end
    // below, above and overwrite of an unread result
    I_CONV_DATA <= 14'h05;
    go(32'h30b);
    rdc("ifgx_lo", A_IFGX, 32'h2);
    I_CONV_DATA <= 14'h100;
    go(32'h30b);
    rdc("ifgx_hi_ov", A_IFGX, 32'he);
    wr(A_CLRX, 32'h2);
    rdc("ifgx_part", A_IFGX, 32'hc);
    wr(A_WSEL, 32'h1);
    I_CONV_DATA <= 14'h40;
    go(32'h30b);
    rdc("ifgx_win1", A_IFGX, 32'he);
    rdc("result_w1", 7'h20, 32'h40);
    wr(A_IE, 32'h0);
    tick(2);
    chk("irq_masked", 32'h0, {31'h0, O_IRQ});
    rdc("ifg_sticky", A_IFG, 32'h1);
    wr(A_IEX, 32'h8);
    tick(2);
    chk("irq_ov", 32'h1, {31'h0, O_IRQ});
    rdc("pndx", A_PNDX, 32'h8);
    wr(A_IEX, 32'h0);
    clr_all();
    // lockout while busy, burst reference, signed format
    I_CONV_DATA <= 14'h10;
    wr(A_CTRL, 32'hab);
    tick(2);
    chk("ref_idle", 32'h0, {31'h0, O_REF_ON});
    wr(A_CTRL, 32'haf);
    rdc("stat_busy", A_STAT, 32'h1);
    chk("ref_busy", 32'h1, {31'h0, O_REF_ON});
    wr(A_WIN0, 32'h0);
    wr(A_CTRL, 32'h0);
    #1;
    chk("mod_kept", 32'h1, {31'h0, O_MOD_ON});
    wr(A_CTRL, 32'h4);
    wait_idle();
    rdc("ifgx_tov", A_IFGX, 32'h12);
    rdc("win0_locked", A_WIN0, 32'h0080_0010);
    rdc("signed", 7'h20, 32'hff90);
    rdc("stat_idle", A_STAT, 32'h0);
    clr_all();
    // timer off: sampling lasts as long as the trigger
    wr(A_CTRL, 32'h3);
    // let the dropped software trigger settle so the pin edge is seen
    tick(1);
    I_TRIG <= 1'b1;
    tick(40);
    #1;
    chk("hold_sample", 32'h1, {31'h0, O_SAMPLE});
    @(posedge I_CLK);
    I_TRIG <= 1'b0;
    wait_idle();
    chk("conv_8bit", int'(DIV_TICKS) * int'(CONV_BASE), ncv);
    clr_all();
    // automatic sequence over locations 2 to 4
    wr(A_WEN, 32'h0);
    wr(A_SEQ, 32'h82);
    go(32'h5b);
    rdc("ifg_seq", A_IFG, 32'h1c);
    rdc("stat_seq", A_STAT, 32'h4);
    clr_all();
    // reference ready
    I_REF_READY <= 1'b1;
    tick(3);
    rdc("ifgx_rdy", A_IFGX, 32'h20);
    results();
  end
endmodule
